// file: core/sscs_pkg.sv
// package: constants and carrier types for the commutation sequencer
package sscs_pkg;
  // *************************************************************
  // widths and cycle counts
  // *************************************************************
  localparam int PWM_W      = 12;
  localparam int TIM_W      = 16;
  localparam int STEP_CNT   = 6;
  localparam logic [2:0] STEP_FIRST = 3'h0;
  localparam logic [2:0] STEP_LAST  = 3'h5;
  localparam logic [PWM_W-1:0] PWM_RST = 12'h000;
  localparam logic [7:0] REP_RST    = 8'h00;
  localparam logic [TIM_W-1:0] TIM_RST = 16'h0000;
  localparam logic [3:0] DEAD_RST   = 4'h2;
  localparam logic [1:0] TES_POS    = 2'h0;

  // one step of the six-step table
  typedef struct packed {
    logic [5:0] output_enable_pattern;
    logic [1:0] input_select;
    logic       comparator_edge_select;
    logic       hardware_demag_enable;
    logic       simulated_demag_enable;
  } sscs_step_t;

  // three duty compare values
  typedef struct packed {
    logic [PWM_W-1:0] u;
    logic [PWM_W-1:0] v;
    logic [PWM_W-1:0] w;
  } sscs_duty_t;

  typedef enum logic [1:0] {
    SSCS_WAIT_Z = 2'b00,
    SSCS_DELAY  = 2'b01,
    SSCS_WAIT_D = 2'b11
  } sscs_state_t;

  typedef enum logic [1:0] {
    SSCS_MODE_POSITION   = 2'b00,
    SSCS_MODE_SENSORLESS = 2'b01,
    SSCS_MODE_SPEED      = 2'b10
  } sscs_mode_t;
endpackage

// file: core/sscs_step_mem.sv
// file: six-entry step configuration memory with registered read
`timescale 1ns/10ps
module sscs_step_mem (
  input  wire logic              clock_in,   // clock
  input  wire logic              rst_in,     // sync reset
  input  wire logic              wr_en_in,   // write strobe
  input  wire logic [2:0]        wr_idx_in,  // write step index
  input  wire sscs_pkg::sscs_step_t wr_data_in, // write data
  input  wire logic [2:0]        rd_idx_in,  // read step index
  output sscs_pkg::sscs_step_t   rd_data_out // registered read
);
  sscs_pkg::sscs_step_t mem_q [sscs_pkg::STEP_CNT];

  always_ff @(posedge clock_in) begin
    if (wr_en_in && wr_idx_in <= sscs_pkg::STEP_LAST) begin
      mem_q[wr_idx_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rd_data_out <= '0;
    end else if (rd_idx_in <= sscs_pkg::STEP_LAST) begin
      rd_data_out <= mem_q[rd_idx_in];
    end else begin
      rd_data_out <= '0;
    end
  end
endmodule

// file: core/sscs_top.sv
// file: six-step commutation sequencer and three-phase pwm update
// Function
// - order z, then c after delay, then d
// - c generated when computed delay elapses
// - d detected or simulated by timer compare
// - z detected or simulated by timer compare
// - sample z only while high side off
// - six complementary outputs with dead time
// - preload copied to compare on update
// - update pulse raised every update event
// - mode from sensor bit and input select
// - speed timer clears on capture, auto prescale, raised only in 16-bit mode
// - 8/16-bit timer with 8x8 multiplier
// - 12-bit free counter with repetition counter
`timescale 1ns/10ps
module sscs_top (
  input  wire logic        clock_in,        // 40 mhz clock
  input  wire logic        rst_in,          // sync reset, high
  input  wire logic        cmp_raw_in,      // comparator pin, async
  input  wire logic        run_in,          // autoswitched enable
  input  wire logic        sensor_mode_bit_in, // 1 = position sensor
  input  wire logic [1:0]  timer_input_select_in, // input block mode
  input  wire logic        timer16_in,      // 16-bit timer use
  input  wire logic [7:0]  delay_weight_in, // delay multiplier
  input  wire logic [15:0] z_sim_cmp_in,    // simulated z compare
  input  wire logic        step_wr_in,      // step table write
  input  wire logic [2:0]  step_idx_in,     // step table index
  input  wire sscs_pkg::sscs_step_t step_data_in, // step table data
  input  wire sscs_pkg::sscs_duty_t duty_pre_in,  // duty preload
  input  wire logic [11:0] pwm_period_in,   // pwm top value
  input  wire logic [7:0]  rep_in,          // repetition reload
  input  wire logic [3:0]  dead_in,         // dead time cycles
  output logic [5:0]       drive_out,       // inverter gate drives
  output logic [5:0]       phase_pwm_out,   // complementary pwm
  output sscs_pkg::sscs_step_t step_cfg_out, // active step config
  output logic [2:0]       step_out,        // active step index
  output logic             z_out,           // z event pulse
  output logic             c_out,           // c event pulse
  output logic             d_out,           // d event pulse
  output logic             update_out,      // update event pulse
  output sscs_pkg::sscs_mode_t mode_out,    // input block mode
  output logic [15:0]      speed_out,       // captured period
  output logic [3:0]       prescale_out     // speed prescaler
);
  // *************************************************************
  // input sync and edge selection
  // *************************************************************
  logic cmp_s1_q, cmp_s2_q, cmp_prev_q;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cmp_s1_q   <= 1'b0;
      cmp_s2_q   <= 1'b0;
      cmp_prev_q <= 1'b0;
    end else begin
      cmp_s1_q   <= cmp_raw_in;
      cmp_s2_q   <= cmp_s1_q;
      cmp_prev_q <= cmp_s2_q;
    end
  end

  sscs_pkg::sscs_step_t step_cfg;
  sscs_pkg::sscs_state_t state_q;
  logic [2:0] step_q;
  logic [15:0] tim_q, cdelay_q, zcap_q;
  logic pwm_hi_q;
  logic rise, fall, z_hw, d_hw, z_sim, d_sim, z_ev, d_ev, c_ev;

  assign rise = cmp_s2_q & ~cmp_prev_q;
  assign fall = ~cmp_s2_q & cmp_prev_q;
  assign z_hw = ~pwm_hi_q &
    (step_cfg.comparator_edge_select ? rise : fall);
  assign d_hw = step_cfg.hardware_demag_enable &
    (step_cfg.simulated_demag_enable ? fall : rise);
  assign z_sim = (tim_q == z_sim_cmp_in);
  assign d_sim = ~step_cfg.hardware_demag_enable &
    (tim_q == (cdelay_q >> 1));

  // *************************************************************
  // event sequencer
  // *************************************************************
  // strict z c d order
  assign z_ev = (state_q == sscs_pkg::SSCS_WAIT_Z) & run_in &
    (z_hw | z_sim);
  assign c_ev = (state_q == sscs_pkg::SSCS_DELAY) & (tim_q >= cdelay_q);
  assign d_ev = (state_q == sscs_pkg::SSCS_WAIT_D) & (d_hw | d_sim);

  always_ff @(posedge clock_in) begin
    if (rst_in || !run_in) begin
      state_q <= sscs_pkg::SSCS_WAIT_Z;
    end else begin
      case (state_q)
        sscs_pkg::SSCS_WAIT_Z: if (z_ev) state_q <= sscs_pkg::SSCS_DELAY;
        sscs_pkg::SSCS_DELAY:  if (c_ev) state_q <= sscs_pkg::SSCS_WAIT_D;
        sscs_pkg::SSCS_WAIT_D: if (d_ev) state_q <= sscs_pkg::SSCS_WAIT_Z;
        default:               state_q <= sscs_pkg::SSCS_WAIT_Z;
      endcase
    end
  end

  // *************************************************************
  // delay manager timer and multiplier
  // *************************************************************
  logic [15:0] product;
  assign product = zcap_q[7:0] * delay_weight_in;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tim_q    <= sscs_pkg::TIM_RST;
      zcap_q   <= sscs_pkg::TIM_RST;
      cdelay_q <= sscs_pkg::TIM_RST;
    end else if (z_ev) begin
      // restart at each z, the count captured at the z before feeds the delay
      zcap_q   <= tim_q;
      cdelay_q <= timer16_in ? product : {8'h00, product[15:8]};
      tim_q    <= sscs_pkg::TIM_RST;
    end else if (c_ev) begin
      tim_q <= sscs_pkg::TIM_RST;
    end else if (timer16_in ? (tim_q != 16'hffff) : (tim_q[7:0] != 8'hff))
    begin
      tim_q <= tim_q + 16'h0001;
    end
  end

  // *************************************************************
  // step advance and outputs
  // *************************************************************
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      step_q <= sscs_pkg::STEP_FIRST;
    end else if (c_ev) begin
      step_q <= (step_q == sscs_pkg::STEP_LAST) ? sscs_pkg::STEP_FIRST
                                                : step_q + 3'h1;
    end
  end

  sscs_step_mem u_mem (
    .clock_in    (clock_in),
    .rst_in      (rst_in),
    .wr_en_in    (step_wr_in),
    .wr_idx_in   (step_idx_in),
    .wr_data_in  (step_data_in),
    .rd_idx_in   (step_q),
    .rd_data_out (step_cfg)
  );

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      z_out <= 1'b0;
      c_out <= 1'b0;
      d_out <= 1'b0;
      step_out <= sscs_pkg::STEP_FIRST;
      step_cfg_out <= '0;
      drive_out <= 6'h00;
    end else begin
      z_out <= z_ev;
      c_out <= c_ev;
      d_out <= d_ev;
      step_out <= step_q;
      step_cfg_out <= step_cfg;
      // pwm chops high side group
      // high sides sit on even bits, low sides stay on
      drive_out <= step_cfg.output_enable_pattern &
        {1'b1, pwm_hi_q, 1'b1, pwm_hi_q, 1'b1, pwm_hi_q};
    end
  end

  // *************************************************************
  // three-phase pwm generator
  // *************************************************************
  logic [11:0] pwm_cnt_q;
  logic [7:0]  rep_q;
  sscs_pkg::sscs_duty_t duty_q;
  logic period_end, upd;
  assign period_end = (pwm_cnt_q >= pwm_period_in);
  assign upd = period_end & (rep_q == 8'h00);

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pwm_cnt_q <= sscs_pkg::PWM_RST;
      rep_q     <= sscs_pkg::REP_RST;
    end else begin
      pwm_cnt_q <= period_end ? sscs_pkg::PWM_RST : pwm_cnt_q + 12'h001;
      if (period_end) begin
        rep_q <= (rep_q == 8'h00) ? rep_in : rep_q - 8'h01;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      duty_q     <= '0;
      update_out <= 1'b0;
    end else begin
      if (upd) duty_q <= duty_pre_in;
      update_out <= upd;
    end
  end

  logic [2:0] ref_q;
  logic [3:0] dt_q [3];
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pwm_hi_q <= 1'b0;
      ref_q    <= 3'h0;
    end else begin
      pwm_hi_q <= pwm_cnt_q < duty_q.u;
      ref_q <= {pwm_cnt_q < duty_q.w, pwm_cnt_q < duty_q.v,
                pwm_cnt_q < duty_q.u};
    end
  end
  for (genvar g = 0; g < 3; g++) begin : g_dt
    logic ref_d1_q;
    always_ff @(posedge clock_in) begin
      if (rst_in) begin
        ref_d1_q <= 1'b0;
        dt_q[g]  <= sscs_pkg::DEAD_RST;
        phase_pwm_out[2*g+1:2*g] <= 2'b00;
      end else begin
        ref_d1_q <= ref_q[g];
        // any edge restarts the dead gap with both sides off
        if (ref_d1_q != ref_q[g]) begin
          dt_q[g] <= dead_in;
          phase_pwm_out[2*g+1:2*g] <= 2'b00;
        // edge cycle is the first gap cycle, so the gap is
        // dead_in cycles, one at the least
        end else if (dt_q[g] > 4'h1) begin
          dt_q[g] <= dt_q[g] - 4'h1;
          phase_pwm_out[2*g+1:2*g] <= 2'b00;
        end else begin
          phase_pwm_out[2*g+1:2*g] <= {~ref_q[g], ref_q[g]};
        end
      end
    end
  end

  // *************************************************************
  // mode select and speed measurement
  // *************************************************************
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      mode_out     <= sscs_pkg::SSCS_MODE_SENSORLESS;
      speed_out    <= sscs_pkg::TIM_RST;
      prescale_out <= 4'h0;
    end else begin
      // mode from sensor bit and select
      if (timer_input_select_in != sscs_pkg::TES_POS)
        mode_out <= sscs_pkg::SSCS_MODE_SPEED;
      else if (sensor_mode_bit_in)
        mode_out <= sscs_pkg::SSCS_MODE_POSITION;
      else
        mode_out <= sscs_pkg::SSCS_MODE_SENSORLESS;
      if (z_ev) begin
        speed_out <= tim_q;
        if (tim_q == 16'hffff && prescale_out != 4'hf)
          prescale_out <= prescale_out + 4'h1;
        else if (tim_q[15:14] == 2'b00 && prescale_out != 4'h0)
          prescale_out <= prescale_out - 4'h1;
      end
    end
  end

  // *************************************************************
  // checks
  // *************************************************************
  chk_z_then_c: assert property (@(posedge clock_in)
    disable iff (rst_in) c_ev |-> $past(state_q) != sscs_pkg::SSCS_WAIT_D)
    else $error("c outside delay phase");
  chk_no_z_early: assert property (@(posedge clock_in)
    disable iff (rst_in) state_q == sscs_pkg::SSCS_WAIT_D |-> !z_ev)
    else $error("z accepted before d");
  chk_c_delay: assert property (@(posedge clock_in)
    disable iff (rst_in) c_ev |-> tim_q >= cdelay_q)
    else $error("c before delay");
  chk_step_wrap: assert property (@(posedge clock_in)
    disable iff (rst_in) c_ev && step_q == 3'h5 |=> step_q == 3'h0)
    else $error("step did not wrap");
  chk_update_load: assert property (@(posedge clock_in)
    disable iff (rst_in) upd |=> duty_q == $past(duty_pre_in))
    else $error("preload not taken");
  chk_update_pulse: assert property (@(posedge clock_in)
    disable iff (rst_in) upd |=> update_out)
    else $error("update pulse missing");
  chk_dead_gap: assert property (@(posedge clock_in)
    disable iff (rst_in) phase_pwm_out[1:0] != 2'b11 &&
    phase_pwm_out[3:2] != 2'b11 && phase_pwm_out[5:4] != 2'b11)
    else $error("shoot through");
  chk_mode_speed: assert property (@(posedge clock_in)
    disable iff (rst_in)
    timer_input_select_in != 2'b00 |=> mode_out == sscs_pkg::SSCS_MODE_SPEED)
    else $error("speed mode not set");
  chk_z_window: assert property (@(posedge clock_in)
    disable iff (rst_in) z_ev && !z_sim |-> !pwm_hi_q)
    else $error("z sampled with high side on");
  chk_pwm_wrap: assert property (@(posedge clock_in)
    disable iff (rst_in) period_end |=> pwm_cnt_q == 12'h000)
    else $error("pwm counter did not restart");
  cov_full_cycle: cover property (@(posedge clock_in) disable iff (rst_in)
    z_ev ##[1:1000] c_ev ##[1:1000] d_ev);
  cov_wrap: cover property (@(posedge clock_in) disable iff (rst_in)
    c_ev && step_q == 3'h5);
  cov_update: cover property (@(posedge clock_in) disable iff (rst_in)
    upd);
endmodule

// file: tb/sscs_motor_model.sv
// partner model: motor windings feeding the bemf comparator pin
`timescale 1ns/10ps
module sscs_motor_model (
  input  wire logic [5:0] drive_in, // gate drives, unused by model
  input  wire logic       clock_in, // system clock
  output logic            cmp_out   // comparator level
);
  initial cmp_out = 1'b1;
  // *************************************************************
  // winding slopes
  // *************************************************************
  // slope and demag start level
  // the line first sits at the far level for lag cycles, so a slope with a nonzero lag is a real edge
  task automatic slope(input logic rise, input int lag);
    @(negedge clock_in);
    cmp_out = ~rise;
    repeat (lag) @(negedge clock_in);
    cmp_out = rise;
  endtask
endmodule

// file: tb/sscs_top_bench.sv
// testbench: event order, step table, modes and pwm update
`timescale 1ns/10ps
module sscs_top_bench;
  logic                 clock_in;
  logic                 rst_in;
  logic                 run_in;
  logic                 sens;
  logic [1:0]           sel;
  logic                 step_wr;
  logic [2:0]           step_idx;
  logic [15:0]          z_sim;
  sscs_pkg::sscs_step_t step_data;
  sscs_pkg::sscs_duty_t duty;
  sscs_pkg::sscs_step_t tbl [6];
  wire                  cmp;
  wire [5:0]            drive_out;
  wire [5:0]            pwm_out;
  sscs_pkg::sscs_step_t step_cfg_out;
  wire [2:0]            step_out;
  wire                  z_out;
  wire                  c_out;
  wire                  d_out;
  wire                  update_out;
  sscs_pkg::sscs_mode_t mode_out;
  wire [15:0]           speed;
  wire [3:0]            presc;
  wire [2:0]            ev = {d_out, c_out, z_out};
  int                   error_cnt = 0;
  int                   checks_done = 0;

  initial clock_in = 1'b0;
  always #12.5 clock_in = ~clock_in;

  sscs_top dut (.clock_in(clock_in), .rst_in(rst_in), .cmp_raw_in(cmp),
    .run_in(run_in), .sensor_mode_bit_in(sens),
    .timer_input_select_in(sel), .timer16_in(1'b0),
    .delay_weight_in(8'h01), .z_sim_cmp_in(z_sim),
    .step_wr_in(step_wr), .step_idx_in(step_idx),
    .step_data_in(step_data), .duty_pre_in(duty),
    .pwm_period_in(12'h00f), .rep_in(8'h00), .dead_in(4'h2),
    .drive_out(drive_out), .phase_pwm_out(pwm_out),
    .step_cfg_out(step_cfg_out), .step_out(step_out), .z_out(z_out),
    .c_out(c_out), .d_out(d_out), .update_out(update_out),
    .mode_out(mode_out), .speed_out(speed), .prescale_out(presc));

  sscs_motor_model mot (.drive_in(drive_out), .clock_in(clock_in),
    .cmp_out(cmp));

  // *************************************************************
  // shared tasks
  // *************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // first event pulse inside a bounded span, zero if none
  task automatic next_ev(input int span, output logic [2:0] got);
    got = 3'h0;
    for (int n = 0; n < span && got == 3'h0; n++) begin
      @(posedge clock_in);
      #1;
      got = ev;
    end
  endtask

  // always pass one edge first, so a pulse left from before the
  // new preload is not taken for its update
  task automatic wait_update;
    int n;
    n = 0;
    do begin
      @(posedge clock_in);
      #1;
      n++;
    end while (n < 100 && update_out !== 1'b1);
  endtask

  // *************************************************************
  // scenarios
  // *************************************************************
  // software step table
  task automatic load_table;
    logic [5:0] oe [6];
    int         dm [6];
    oe = '{6'h09, 6'h21, 6'h24, 6'h06, 6'h12, 6'h18};
    dm = '{3, 0, 5, 2, 1, 4};
    for (int i = 0; i < 6; i++) begin
      tbl[i] = {oe[i], 2'(2 - i % 3), i[0], 1'b1, i[0]};
      // demag driver is powered, low side on even steps
      check(16'({oe[i][dm[i]], dm[i][0]}), 16'({1'b1, ~i[0]}));
      @(negedge clock_in);
      step_wr <= 1'b1;
      step_idx <= 3'(i);
      step_data <= tbl[i];
    end
    @(negedge clock_in);
    step_wr <= 1'b0;
  endtask

  task automatic t_mode;
    for (int k = 0; k < 5; k++) begin
      @(negedge clock_in);
      sens <= (k == 0);
      sel <= 2'(k > 1 ? k - 1 : 0);
      repeat (3) @(posedge clock_in);
      #1;
      check(16'(mode_out), 16'(k == 0 ? 0 : (k == 1 ? 1 : 2)));
    end
    @(negedge clock_in);
    sens <= 1'b0;
    sel <= 2'h0;
  endtask

  // one full z, c, d round on step s; the z slope lag runs 0, 1, 2 cycles with s
  task automatic t_step(input int s);
    logic [2:0] got;
    int         j;
    j = (s + 1) % 6;
    fork
      mot.slope(tbl[s].comparator_edge_select, s % 3);
      next_ev(60, got);
    join
    check(16'(got), 16'h1);
    next_ev(60, got);
    check(16'(got), 16'h2);
    repeat (3) @(posedge clock_in);
    #1;
    check(16'(step_out), 16'(j));
    check(16'(step_cfg_out), 16'(tbl[j]));
    check(16'(drive_out), 16'(tbl[j][10:5] & 6'h2a));
    // the far level first gives a z slope, which must be ignored
    fork
      mot.slope(~tbl[j].simulated_demag_enable, 8);
      next_ev(60, got);
    join
    check(16'(got), 16'h4);
  endtask

  task automatic t_simz;
    logic [2:0] got;
    @(negedge clock_in);
    z_sim <= 16'h0030;
    next_ev(1000, got);
    check(16'(got), 16'h1);
    check(speed, 16'h0030);
    check(16'(presc), 16'h0000);
    next_ev(60, got);
    check(16'(got), 16'h2);
    @(negedge clock_in);
    run_in <= 1'b0;
  endtask

  task automatic t_pwm;
    int n;
    n = 0;
    @(negedge clock_in);
    duty <= {3{12'hfff}};
    wait_update();
    repeat (8) @(posedge clock_in);
    #1;
    check(16'(pwm_out), 16'h15);
    @(negedge clock_in);
    duty <= {3{12'h000}};
    wait_update();
    repeat (10) begin
      @(posedge clock_in);
      #1;
      n += (pwm_out[1:0] == 2'b00);
    end
    check(16'(n), 16'h2);
    check(16'(pwm_out), 16'h2a);
    n = 0;
    repeat (64) begin
      @(posedge clock_in);
      #1;
      n += (update_out === 1'b1);
    end
    check(16'(n), 16'h4);
  endtask

  // *************************************************************
  // main sequence and watchdog
  // *************************************************************
  initial begin
    rst_in = 1'b1;
    run_in = 1'b0;
    sens = 1'b0;
    sel = 2'h0;
    step_wr = 1'b0;
    step_idx = 3'h0;
    step_data = '0;
    duty = '0;
    z_sim = 16'hffff;
    repeat (4) @(posedge clock_in);
    @(negedge clock_in);
    rst_in <= 1'b0;
    load_table();
    t_mode();
    @(negedge clock_in);
    run_in <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      t_step(i % 6);
    end
    t_simz();
    t_pwm();
    tally_and_finish();
  end

  // whole run is a few hundred cycles; this is over twenty times that
  initial begin
    repeat (20000) @(posedge clock_in);
    error_cnt++;
    tally_and_finish();
  end
endmodule
